// [logic/code_lock_params.svh]
// Constants shared by the code-lock package, link and both ends.
// Assumes inclusion by bare name from files under logic/.
`ifndef CODE_LOCK_PARAMS_SVH
`define CODE_LOCK_PARAMS_SVH

`define IMG_AW 13
`define CODE_AW 12
`define BYTE_W 8
`define CODE_BYTES 4096
`define KEY_BYTES 64
`define KEY_IDX_W 6
`define CODE_LAST 13'h0fff
`define KEY_BASE 13'h1000
`define KEY_LAST 13'h103f
`define LOCK_ADDR 13'h1040
`define LOCK1_BIT 0
`define LOCK2_BIT 1
`define ERASED_BYTE 8'hff
`define CAPTURE_CNT_W 2
`define EA_CAPTURE_CNT 2'h2

`define OFS_W 4
`define OFS_CMD 4'h0
`define OFS_ADDR 4'h4
`define OFS_WDATA 4'h8
`define OFS_STATUS 4'hc
`define CMD_START_BIT 0
`define CMD_WRITE_BIT 1
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1
`define ST_REFUSED_BIT 2
`define ST_RDATA_LSB 8
`define ST_RDATA_MSB 15

`endif

// [logic/code_lock_pkg.sv]
// Types for the code-lock block: image regions and controller states.
// Assumes code_lock_params.svh is on the include path.
`include "code_lock_params.svh"

package code_lock_pkg;

    typedef enum logic [1:0] {
        REGION_CODE,
        REGION_KEY,
        REGION_LOCK,
        REGION_NONE
    } region_t;

    typedef enum {
        HOST_IDLE,
        HOST_WAIT
    } host_state_t;

    function automatic region_t region_of(logic [`IMG_AW-1:0] a);
        region_t r;
        r = REGION_NONE;
        if (a <= `CODE_LAST) begin
            r = REGION_CODE;
        end else if (a >= `KEY_BASE && a <= `KEY_LAST) begin
            r = REGION_KEY;
        end else if (a == `LOCK_ADDR) begin
            r = REGION_LOCK;
        end
        return r;
    endfunction

endpackage

// [logic/code_link_if.sv]
// Link between the verify/programming station and the protected memory.
// Request held by the station until the device answers with ack.
`include "code_lock_params.svh"

interface code_link_if;
    logic req;
    logic wr;
    logic [`IMG_AW-1:0] addr;
    logic [`BYTE_W-1:0] wdata;
    logic ack;
    logic refused;
    logic [`BYTE_W-1:0] rdata;

    modport dev (
        input req, wr, addr, wdata,
        output ack, refused, rdata
    );

    modport prog (
        output req, wr, addr, wdata,
        input ack, refused, rdata
    );
endinterface

// [logic/code_lock_dev.sv]
// Protected program memory: code store, encryption key, lock bits.
// Assumes a station on the link and a core issuing table reads, one clock.
//
// The register addresses and the AHB-Lite register port were decided locally.
`include "code_lock_params.svh"

// Contract
// - Unlocked part allows verify readout.
// - Programmed key makes verify data encrypted.
// - Encrypted byte is XNOR with key; key unreadable.
// - 64 key bytes read all ones initially.
// - First lock blocks external table reads.
// - First lock latches access select at reset.
// - OTP part with first lock refuses programming.
// - Both locks refuse verify readout.
// - Mask part: first lock has two effects.
// - Second lock bit only with first.
// - Other lock settings undefined, not used.
// - Image code at 0000H to 0FFFH.
// - Image key at 1000H to 103FH.
module code_lock_dev
    import code_lock_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    code_link_if.dev LINK,
    input wire logic ERASE_IN,
    input wire logic MASK_PART_IN,
    input wire logic EXT_ACCESS_PIN_IN,
    input wire logic TBL_RD_IN,
    input wire logic TBL_FROM_EXT_IN,
    input wire logic [`CODE_AW-1:0] TBL_ADDR_IN,
    output logic TBL_VALID_OUT,
    output logic TBL_BLOCKED_OUT,
    output logic [`BYTE_W-1:0] TBL_DATA_OUT,
    output logic EXT_ACCESS_OUT,
    output logic LOCK1_OUT,
    output logic LOCK2_OUT,
    output logic KEY_SET_OUT
);

    // Nonvolatile contents: no reset; erase clears key, lock and key-set bits, never the code store
    logic [`BYTE_W-1:0] code_mem [`CODE_BYTES];
    logic [`BYTE_W-1:0] key_mem [`KEY_BYTES];
    logic lock1_q;
    logic lock2_q;
    logic key_set_q;

    logic ext_s1_q;
    logic ext_s2_q;
    logic mask_s1_q;
    logic mask_s2_q;
    logic ext_lat_q;
    logic mask_q;
    logic [`CAPTURE_CNT_W-1:0] cap_cnt_q;
    logic captured_q;

    logic ack_q;
    logic refused_q;
    logic [`BYTE_W-1:0] rdata_q;

    logic tbl_valid_q;
    logic tbl_blocked_q;
    logic [`BYTE_W-1:0] tbl_data_q;

    logic take;
    region_t region;
    logic [`CODE_AW-1:0] code_idx;
    logic [`KEY_IDX_W-1:0] key_idx;
    logic prog_locked;
    logic verify_locked;
    logic write_ok;
    logic read_ok;
    logic [`BYTE_W-1:0] raw_byte;
    logic [`BYTE_W-1:0] verify_byte;

    assign take = LINK.req && !ack_q;
    assign region = region_of(LINK.addr);
    assign code_idx = LINK.addr[`CODE_AW-1:0];
    assign key_idx = LINK.addr[`KEY_IDX_W-1:0];

    // Mask parts keep programming open whatever the first bit says
    assign prog_locked = lock1_q && !mask_q;
    // Second bit alone is left undefined; guarded only as a pair
    assign verify_locked = lock1_q && lock2_q;

    // Lock bits stay programmable after the first one is set
    always_comb begin
        write_ok = 1'b0;
        case (region)
            REGION_CODE: write_ok = !prog_locked;
            REGION_KEY: write_ok = !prog_locked;
            REGION_LOCK: write_ok = 1'b1;
            default: write_ok = 1'b0;
        endcase
    end

    // Only code is ever read back; key and lock byte never leave
    assign read_ok = (region == REGION_CODE) && !verify_locked;

    assign raw_byte = code_mem[code_idx];
    assign verify_byte = key_set_q ?
        ~(raw_byte ^ key_mem[key_idx]) : raw_byte;

    // Pin and strap come from outside: two flops before any logic
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            mask_s1_q <= 1'b0;
            mask_s2_q <= 1'b0;
        end else begin
            ext_s1_q <= EXT_ACCESS_PIN_IN;
            ext_s2_q <= ext_s1_q;
            mask_s1_q <= MASK_PART_IN;
            mask_s2_q <= mask_s1_q;
        end
    end

    // Sample once after release, when the synchroniser holds the pin
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            cap_cnt_q <= '0;
            captured_q <= 1'b0;
            ext_lat_q <= 1'b0;
            mask_q <= 1'b0;
        end else if (!captured_q) begin
            if (cap_cnt_q == `EA_CAPTURE_CNT) begin
                captured_q <= 1'b1;
                ext_lat_q <= ext_s2_q;
                mask_q <= mask_s2_q;
            end else begin
                cap_cnt_q <= cap_cnt_q + 1'b1;
            end
        end
    end

    // Live pin until both the sample is taken and the first bit is set; latched copy then
    assign EXT_ACCESS_OUT = (lock1_q && captured_q) ?
        ext_lat_q : ext_s2_q;

    always_ff @(posedge REF_CLK_IN) begin
        if (take && LINK.wr && write_ok && region == REGION_CODE) begin
            code_mem[code_idx] <= LINK.wdata;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (ERASE_IN) begin
            for (int i = 0; i < `KEY_BYTES; i++) begin
                key_mem[i] <= `ERASED_BYTE;
            end
        end else if (take && LINK.wr && write_ok &&
                     region == REGION_KEY) begin
            key_mem[key_idx] <= LINK.wdata;
        end
    end

    // Programmed bits cannot be undone except by erase
    always_ff @(posedge REF_CLK_IN) begin
        if (ERASE_IN) begin
            lock1_q <= 1'b0;
            lock2_q <= 1'b0;
        end else if (take && LINK.wr && region == REGION_LOCK) begin
            lock1_q <= lock1_q | LINK.wdata[`LOCK1_BIT];
            lock2_q <= lock2_q | LINK.wdata[`LOCK2_BIT];
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (ERASE_IN) begin
            key_set_q <= 1'b0;
        end else if (take && LINK.wr && write_ok &&
                     region == REGION_KEY) begin
            key_set_q <= 1'b1;
        end
    end

    // One-cycle answer to every request
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ack_q <= 1'b0;
            refused_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= take;
            if (take) begin
                if (LINK.wr) begin
                    refused_q <= !write_ok;
                    rdata_q <= '0;
                end else begin
                    refused_q <= !read_ok;
                    rdata_q <= read_ok ? verify_byte : '0;
                end
            end
        end
    end

    assign LINK.ack = ack_q;
    assign LINK.refused = refused_q;
    assign LINK.rdata = rdata_q;

    // External-origin table reads see zero instead of internal code once the first lock is set
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tbl_valid_q <= 1'b0;
            tbl_blocked_q <= 1'b0;
            tbl_data_q <= '0;
        end else begin
            tbl_valid_q <= TBL_RD_IN;
            tbl_blocked_q <= TBL_RD_IN && TBL_FROM_EXT_IN && lock1_q;
            if (TBL_RD_IN) begin
                if (TBL_FROM_EXT_IN && lock1_q) begin
                    tbl_data_q <= '0;
                end else begin
                    tbl_data_q <= code_mem[TBL_ADDR_IN];
                end
            end
        end
    end

    assign TBL_VALID_OUT = tbl_valid_q;
    assign TBL_BLOCKED_OUT = tbl_blocked_q;
    assign TBL_DATA_OUT = tbl_data_q;
    assign LOCK1_OUT = lock1_q;
    assign LOCK2_OUT = lock2_q;
    assign KEY_SET_OUT = key_set_q;

endmodule

// [logic/code_lock_prog.sv]
// Verify/programming station: AHB-Lite registers drive the code link.
// Assumes one AHB-Lite master, single word transfers, one clock.
`include "code_lock_params.svh"

module code_lock_prog
    import code_lock_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    code_link_if.prog LINK
);

    host_state_t state_q;
    logic ap_valid_q;
    logic ap_write_q;
    logic [`OFS_W-1:0] ap_ofs_q;
    logic [`IMG_AW-1:0] addr_q;
    logic [`BYTE_W-1:0] wdata_q;
    logic wr_q;
    logic done_q;
    logic refused_q;
    logic [`BYTE_W-1:0] rdata_q;
    logic [31:0] hrdata_q;
    logic [31:0] status;
    logic cmd_wr;
    logic start;
    logic local_refuse;
    logic [`BYTE_W-1:0] next_wdata;

    // Zero wait states; size is ignored, every access is a word
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT = 1'b0;

    assign cmd_wr = ap_valid_q && ap_write_q && ap_ofs_q == `OFS_CMD;
    assign start = cmd_wr && HWDATA_IN[`CMD_START_BIT] &&
                   state_q == HOST_IDLE;
    assign next_wdata = wdata_q;

    // Image beyond the lock byte, or second bit without the first
    assign local_refuse = (region_of(addr_q) == REGION_NONE) ||
        (HWDATA_IN[`CMD_WRITE_BIT] && addr_q == `LOCK_ADDR &&
         next_wdata[`LOCK2_BIT] && !next_wdata[`LOCK1_BIT]);

    always_comb begin
        status = '0;
        status[`ST_BUSY_BIT] = state_q == HOST_WAIT;
        status[`ST_DONE_BIT] = done_q;
        status[`ST_REFUSED_BIT] = refused_q;
        status[`ST_RDATA_MSB:`ST_RDATA_LSB] = rdata_q;
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_ofs_q <= '0;
        end else if (HREADY_IN) begin
            ap_valid_q <= HSEL_IN && HTRANS_IN[1];
            ap_write_q <= HWRITE_IN;
            ap_ofs_q <= HADDR_IN[`OFS_W-1:0];
        end
    end

    // Read data loaded from the address phase, stands in the data phase
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            hrdata_q <= '0;
        end else if (HREADY_IN && HSEL_IN && HTRANS_IN[1] && !HWRITE_IN) begin
            case (HADDR_IN[`OFS_W-1:0])
                `OFS_ADDR: hrdata_q <= {19'h0, addr_q};
                `OFS_WDATA: hrdata_q <= {24'h0, wdata_q};
                `OFS_STATUS: hrdata_q <= status;
                default: hrdata_q <= '0;
            endcase
        end
    end

    assign HRDATA_OUT = hrdata_q;

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            addr_q <= '0;
            wdata_q <= '0;
        end else if (ap_valid_q && ap_write_q && state_q == HOST_IDLE) begin
            if (ap_ofs_q == `OFS_ADDR) begin
                addr_q <= HWDATA_IN[`IMG_AW-1:0];
            end
            if (ap_ofs_q == `OFS_WDATA) begin
                wdata_q <= HWDATA_IN[`BYTE_W-1:0];
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q <= HOST_IDLE;
            wr_q <= 1'b0;
            done_q <= 1'b0;
            refused_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            case (state_q)
                HOST_IDLE: begin
                    if (start) begin
                        wr_q <= HWDATA_IN[`CMD_WRITE_BIT];
                        rdata_q <= '0;
                        refused_q <= local_refuse;
                        done_q <= local_refuse;
                        if (!local_refuse) begin
                            state_q <= HOST_WAIT;
                        end
                    end
                end
                HOST_WAIT: begin
                    if (LINK.ack) begin
                        refused_q <= LINK.refused;
                        rdata_q <= LINK.rdata;
                        done_q <= 1'b1;
                        state_q <= HOST_IDLE;
                    end
                end
                default: state_q <= HOST_IDLE;
            endcase
        end
    end

    assign LINK.req = state_q == HOST_WAIT;
    assign LINK.wr = wr_q;
    assign LINK.addr = addr_q;
    assign LINK.wdata = wdata_q;

endmodule

// [verification/code_lock_sva.sv]
// Checker on the link between the station and the protected memory.
// Assumes instantiation beside the link interface, signals by name.
`include "code_lock_params.svh"
module code_lock_sva (
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic req,
    input wire logic wr,
    input wire logic [`IMG_AW-1:0] addr,
    input wire logic [`BYTE_W-1:0] wdata,
    input wire logic ack,
    input wire logic refused,
    input wire logic [`BYTE_W-1:0] rdata
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    AST_ACK_ONE_LATER: assert property ($rose(req) |-> !ack ##1 ack)
        else $error("ack not one cycle after request");
    AST_ACK_PULSE: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (ack |-> $past(req))
        else $error("ack without request");
    AST_REQ_RELEASE: assert property (ack |=> !req)
        else $error("request held after ack");
    AST_REQ_HOLD: assert property (req && !ack |=> $stable({wr, addr, wdata}))
        else $error("request fields changed while waiting");
    AST_KEY_HIDDEN: assert property (ack && !wr && addr >= `KEY_BASE
        |-> refused && rdata == 8'h00)
        else $error("key or lock byte readable");
    AST_WRITE_NO_DATA: assert property (ack && wr |-> rdata == 8'h00)
        else $error("data returned on a write");
    AST_REFUSE_NO_DATA: assert property (ack && refused |-> rdata == 8'h00)
        else $error("data returned with refusal");
    AST_LOCK_PAIR: assert property (req && wr && addr == `LOCK_ADDR
        |-> wdata[1:0] != 2'b10)
        else $error("second lock bit sent alone");
    AST_ADDR_MAPPED: assert property (req |-> addr <= `LOCK_ADDR)
        else $error("request to unmapped image address");
endmodule

// [verification/code_memory_security_lock_tb.sv]
// Self-checking bench: station and device joined by the code link.
// Assumes the design files under logic/ and the checker are compiled first.
module code_memory_security_lock_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n = 1'b0, hsel, hwrite, erase, mask = 1'b0, pin;
    logic tbl_rd, tbl_ext, tbl_valid, tbl_blk, ext_out, l1, l2, kset;
    logic hready, hresp, m_key, m_l1, m_l2, m_mask;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [11:0] tbl_addr, a;
    logic [7:0] tbl_data;
    logic [7:0] code_m [4096];
    logic [7:0] key_m [64];
    logic [11:0] progd[$];
    int errors = 0, check_count = 0, cyc = 0, seed;
    code_link_if link ();
    code_lock_dev i_code_lock_dev (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
        .LINK(link), .ERASE_IN(erase), .MASK_PART_IN(mask),
        .EXT_ACCESS_PIN_IN(pin), .TBL_RD_IN(tbl_rd), .TBL_FROM_EXT_IN(tbl_ext),
        .TBL_ADDR_IN(tbl_addr), .TBL_VALID_OUT(tbl_valid),
        .TBL_BLOCKED_OUT(tbl_blk), .TBL_DATA_OUT(tbl_data),
        .EXT_ACCESS_OUT(ext_out), .LOCK1_OUT(l1), .LOCK2_OUT(l2),
        .KEY_SET_OUT(kset));
    code_lock_prog i_code_lock_prog (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
        .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
        .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
        .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
        .HRESP_OUT(hresp), .LINK(link));
    code_lock_sva i_code_lock_sva (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
        .req(link.req), .wr(link.wr), .addr(link.addr), .wdata(link.wdata),
        .ack(link.ack), .refused(link.refused), .rdata(link.rdata));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic ahb(logic w, logic [3:0] ad, logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {28'h0, ad};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic flags();
        chk("lock1", {7'h0, m_l1}, {7'h0, l1});
        chk("lock2", {7'h0, m_l2}, {7'h0, l2});
        chk("keyset", {7'h0, m_key}, {7'h0, kset});
    endtask
    // Model decides refusal from address, data and lock state; verify data from its memory copy and key flag
    task automatic op(logic w, logic [12:0] ad, logic [7:0] d);
        logic [31:0] r;
        logic rf;
        logic [7:0] e;
        ahb(1'b1, 4'h4, {19'h0, ad}, r);
        ahb(1'b1, 4'h8, {24'h0, d}, r);
        ahb(1'b0, 4'h4, 32'h0, r);
        chk("addr_lo", ad[7:0], r[7:0]);
        chk("addr_hi", {3'h0, ad[12:8]}, r[15:8]);
        ahb(1'b0, 4'h8, 32'h0, r);
        chk("wdata", d, r[7:0]);
        ahb(1'b1, 4'h0, {30'h0, w, 1'b1}, r);
        // Write data phase leaves the last read value, the wdata register, on the read bus
        r = 32'h0;
        for (int i = 0; i < 20 && r[1:0] !== 2'b10; i++) begin
            ahb(1'b0, 4'hc, 32'h0, r);
        end
        chk("done", 8'h01, {7'h0, r[1]});
        chk("hresp", 8'h00, {7'h0, hresp});
        rf = ad > 13'h1040 || (w && ad == 13'h1040 && d[1:0] == 2'b10)
            || (w && ad < 13'h1040 && m_l1 && !m_mask)
            || (!w && (ad > 13'h0fff || (m_l1 && m_l2)));
        e = 8'h00;
        if (!rf && !w) begin
            e = m_key ? ~(code_m[ad] ^ key_m[ad[5:0]]) : code_m[ad];
        end
        if (!rf && w && ad <= 13'h0fff) begin
            code_m[ad] = d;
        end else if (!rf && w && ad < 13'h1040) begin
            key_m[ad[5:0]] = d;
            m_key = 1'b1;
        end else if (!rf && w) begin
            m_l1 |= d[0];
            m_l2 |= d[1];
        end
        chk("refused", {7'h0, rf}, {7'h0, r[2]});
        chk("vdata", e, r[15:8]);
    endtask
    task automatic tbl(logic ext, logic [11:0] ad);
        logic b;
        tbl_rd <= 1'b1;
        tbl_ext <= ext;
        tbl_addr <= ad;
        @(posedge clk);
        tbl_rd <= 1'b0;
        // Valid stands for one cycle only: look before the next edge
        #1;
        b = ext && m_l1;
        chk("tvalid", 8'h01, {7'h0, tbl_valid});
        chk("tblk", {7'h0, b}, {7'h0, tbl_blk});
        chk("tdata", b ? 8'h00 : code_m[ad], tbl_data);
        @(posedge clk);
    endtask
    task automatic reset_dut(logic mk);
        rst_n <= 1'b0;
        mask <= mk;
        m_mask = mk;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic sweep();
        foreach (progd[i]) begin
            op(1'b0, {1'b0, progd[i]}, 8'h00);
            tbl(progd[i][0], progd[i]);
        end
    endtask
    initial begin
        seed = 32'hb82254a0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        {erase, tbl_rd, tbl_ext, tbl_addr, pin} = '0;
        {m_l1, m_l2, m_key} = '0;
        foreach (key_m[i]) key_m[i] = 8'hff;
        reset_dut(1'b0);
        erase <= 1'b1;
        @(posedge clk);
        erase <= 1'b0;
        pin <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("ext", 8'h01, {7'h0, ext_out});
        @(posedge clk);
        flags();
        for (int i = 0; i < 10; i++) begin
            a = (i < 2) ? 12'hfff * i[11:0] : 12'($random(seed));
            op(1'b1, {1'b0, a}, 8'($random(seed)));
            progd.push_back(a);
        end
        sweep();
        op(1'b1, 13'h1000 | {7'h0, progd[2][5:0]}, 8'($random(seed)));
        op(1'b1, 13'h103f, 8'($random(seed)));
        flags();
        sweep();
        op(1'b0, 13'h1000, 8'h00);
        op(1'b0, 13'h1040, 8'h00);
        op(1'b1, 13'h1041, 8'h5a);
        op(1'b1, 13'h1040, 8'h02);
        op(1'b1, 13'h1040, 8'h01);
        flags();
        op(1'b1, {1'b0, progd[0]}, 8'h33);
        op(1'b1, 13'h1005, 8'h44);
        sweep();
        reset_dut(1'b0);
        pin <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("ext", 8'h01, {7'h0, ext_out});
        @(posedge clk);
        reset_dut(1'b1);
        pin <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("ext", 8'h00, {7'h0, ext_out});
        @(posedge clk);
        op(1'b1, {1'b0, progd[0]}, 8'h3c);
        sweep();
        op(1'b1, 13'h1040, 8'h03);
        flags();
        sweep();
        results();
    end
endmodule
